// ---- src/gmc_gpio_top.sv ----
// Mode decode, pin drive and data registers for six multi-function pins.
// Assumes a synchronous byte register port; tracking, fault, watchdog and margin
// engines live outside and exchange plain levels with this block.
// Functional notes
// (RQ1) Three-bit mode fields packed per pin
// (RQ2) Pin three mode split over two bytes
// (RQ3) Pin six mode split; upper bits reserved
// (RQ4) Reserved codes select no pin function
// (RQ5) Software never writes reserved mode codes
// (RQ6) Codes 001/010/101 give logic pin roles
// (RQ7) Code 000 sense return or margin disable
// (RQ8) Sense compared against ramp drives gate
// (RQ9) Sense follows ramp until power good
// (RQ10) Pulldown control bits switch sense pulldowns
// (RQ11) Logic outputs driven from output register
// (RQ12) Output bits zero to five map pins
// (RQ13) Input register read-only, writes ignored
// (RQ14) Input bits zero to five report pins
// (RQ15) Data registers not loaded from memory
// (RQ16) Pins one-four any-fault active low outputs
// (RQ17) Pins five-six dedicated fault outputs
// (RQ18) Code 111/110 special functions per pin
// (RQ19) Push-pull drives both, open-drain low only
// (RQ20) Output bit ignored outside logic modes
`timescale 1ns/1ps
module gmc_gpio_top #(
	parameter int NUM_PINS = gmc_pkg::NUM_PINS
) (
	input wire logic CLK_SYS_I,
	input wire logic RESET_N_I,
	input wire gmc_pkg::gmc_req_t REQ_I,
	output logic [7:0] RDATA_O,
	input wire logic [NUM_PINS-1:0] PIN_I,
	output logic [NUM_PINS-1:0] PIN_O,
	output logic [NUM_PINS-1:0] PIN_OE_O,
	input wire gmc_pkg::gmc_func_t FUNC_I,
	input wire logic [3:0] TRACK_RAMP_ABOVE_I,
	input wire logic [3:0] TRACK_POWER_GOOD_I,
	output logic [3:0] GATE_DRIVE_EN_O,
	output logic [3:0] SENSE_PULLDOWN_EN_O,
	output logic [3:0] TRACKING_SENSE_RETURN_SEL_O,
	output logic MARGIN_DISABLE_N_O,
	output logic MARGIN_RAISE_INPUT_N_O,
	output logic MARGIN_LOWER_INPUT_N_O,
	output logic MANUAL_RESET_INPUT_N_O,
	output logic WATCHDOG_KICK_INPUT_O,
	output logic [NUM_PINS-1:0] RESERVED_MODE_O
);
	logic [7:0] out_levels_q;
	logic [7:0] cfg_low_q;
	logic [7:0] cfg_mid_q;
	logic [7:0] cfg_high_q;
	logic [7:0] pulldown_q;
	logic [NUM_PINS-1:0] pin_meta_q;
	logic [NUM_PINS-1:0] pin_sync_q;
	logic [7:0] rdata_q;
	logic [NUM_PINS-1:0] pin_o_q;
	logic [NUM_PINS-1:0] pin_oe_q;
	logic [NUM_PINS-1:0] reserved_q;
	logic [3:0] gate_q;
	logic [3:0] pulldown_en_q;
	logic [3:0] sense_sel_q;
	logic margin_dis_q;
	logic margin_up_q;
	logic margin_dn_q;
	logic mreset_q;
	logic wdi_q;

	// Address decode; register space differs by page
	wire wr_out = REQ_I.wr && REQ_I.ext_page && REQ_I.addr == gmc_pkg::OFF_OUT_LEVELS;
	wire wr_low = REQ_I.wr && !REQ_I.ext_page && REQ_I.addr == gmc_pkg::OFF_CFG_LOW;
	wire wr_mid = REQ_I.wr && !REQ_I.ext_page && REQ_I.addr == gmc_pkg::OFF_CFG_MID;
	wire wr_high = REQ_I.wr && !REQ_I.ext_page && REQ_I.addr == gmc_pkg::OFF_CFG_HIGH;
	wire wr_pd = REQ_I.wr && !REQ_I.ext_page && REQ_I.addr == gmc_pkg::OFF_PULLDOWN;

	// Mode field assembly
	gmc_pkg::gmc_mode_t mode [NUM_PINS];
	assign mode[0] = gmc_pkg::gmc_mode_t'(cfg_low_q[gmc_pkg::PIN1_LSB +: 3]); // [RQ1]
	assign mode[1] = gmc_pkg::gmc_mode_t'(cfg_low_q[gmc_pkg::PIN2_LSB +: 3]); // [RQ1]
	assign mode[2] = gmc_pkg::gmc_mode_t'({cfg_mid_q[gmc_pkg::PIN3_HI_BIT],
		cfg_low_q[gmc_pkg::PIN3_LO_LSB +: 2]}); // [RQ2]
	assign mode[3] = gmc_pkg::gmc_mode_t'(cfg_mid_q[gmc_pkg::PIN4_LSB +: 3]); // [RQ1]
	assign mode[4] = gmc_pkg::gmc_mode_t'(cfg_mid_q[gmc_pkg::PIN5_LSB +: 3]); // [RQ1]
	assign mode[5] = gmc_pkg::gmc_mode_t'({cfg_high_q[gmc_pkg::PIN6_HI_LSB +: 2],
		cfg_mid_q[gmc_pkg::PIN6_LO_BIT]}); // [RQ3]

	// Input data read view
	wire [7:0] in_levels = {2'h0, pin_sync_q}; // [RQ14]

	wire [7:0] rd_mux =
		(REQ_I.ext_page && REQ_I.addr == gmc_pkg::OFF_OUT_LEVELS) ? {2'h0, out_levels_q[5:0]} :
		(REQ_I.ext_page && REQ_I.addr == gmc_pkg::OFF_IN_LEVELS) ? in_levels :
		(!REQ_I.ext_page && REQ_I.addr == gmc_pkg::OFF_CFG_LOW) ? cfg_low_q :
		(!REQ_I.ext_page && REQ_I.addr == gmc_pkg::OFF_CFG_MID) ? cfg_mid_q :
		(!REQ_I.ext_page && REQ_I.addr == gmc_pkg::OFF_CFG_HIGH) ? cfg_high_q :
		(!REQ_I.ext_page && REQ_I.addr == gmc_pkg::OFF_PULLDOWN) ? pulldown_q :
		gmc_pkg::UNMAPPED_READ;

	// Per-pin drive decode
	logic [NUM_PINS-1:0] drv_val;
	logic [NUM_PINS-1:0] drv_oe;
	logic [NUM_PINS-1:0] rsvd;
	for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
		wire is_pp_io = mode[p] == gmc_pkg::MODE_PUSH_PULL_IO; // [RQ6]
		wire is_od_io = mode[p] == gmc_pkg::MODE_OPEN_DRAIN_IO; // [RQ6]
		wire is_fpp = mode[p] == gmc_pkg::MODE_FAULT_PP;
		wire is_fod = mode[p] == gmc_pkg::MODE_FAULT_OD;
		wire is_od_spec = (p == 5) && (mode[p] == gmc_pkg::MODE_CODE6 ||
			mode[p] == gmc_pkg::MODE_CODE7); // [RQ18]
		// Fault source per pin: any-fault on 1-4, dedicated on 5 and 6
		wire fault_n = (p < 4) ? FUNC_I.any_fault_n :
			(p == 4) ? FUNC_I.first_fault_n : FUNC_I.second_fault_n; // [RQ16] [RQ17]
		wire spec_n = (mode[p] == gmc_pkg::MODE_CODE6) ? FUNC_I.watchdog_expiry_n :
			FUNC_I.fault_on_powerup_n; // [RQ18]
		// Data bit only matters in logic I/O modes
		wire level = (is_pp_io || is_od_io) ? out_levels_q[p] :
			(is_fpp || is_fod) ? fault_n : spec_n; // [RQ11] [RQ12] [RQ20]
		assign drv_val[p] = level;
		// Open-drain releases the pin for a high level
		assign drv_oe[p] = is_pp_io || is_fpp ||
			((is_od_io || is_fod || is_od_spec) && !level); // [RQ19]
		assign rsvd[p] = (mode[p] == gmc_pkg::MODE_CODE6 && p <= 3) ||
			(mode[p] == gmc_pkg::MODE_CODE7 && p == 0) ||
			(p == 4 && (mode[p] == gmc_pkg::MODE_SENSE ||
			mode[p] == gmc_pkg::MODE_CODE6)); // [RQ4] [RQ5]
	end

	// Tracking channel decode on pins 1-4
	logic [3:0] sense_sel;
	for (genvar t = 0; t < 4; t++) begin : g_trk
		assign sense_sel[t] = mode[t] == gmc_pkg::MODE_SENSE; // [RQ7]
	end
	// Gate enabled while ramp leads sense, held on after power good
	wire [3:0] gate_d = sense_sel & (TRACK_RAMP_ABOVE_I | TRACK_POWER_GOOD_I); // [RQ8] [RQ9]

	wire margin_dis_d = !(mode[5] == gmc_pkg::MODE_SENSE && !pin_sync_q[5]); // [RQ7]
	wire margin_up_d = !(mode[1] == gmc_pkg::MODE_CODE7 && !pin_sync_q[1]); // [RQ18]
	wire margin_dn_d = !(mode[2] == gmc_pkg::MODE_CODE7 && !pin_sync_q[2]); // [RQ18]
	wire mreset_d = !(mode[3] == gmc_pkg::MODE_CODE7 && !pin_sync_q[3]); // [RQ18]
	wire wdi_d = mode[4] == gmc_pkg::MODE_CODE7 && pin_sync_q[4]; // [RQ18]
	wire [3:0] pd_d = pulldown_q[gmc_pkg::PULLDOWN_LSB +: 4]; // [RQ10]

	// Pins are asynchronous to the core clock
	always_ff @(posedge CLK_SYS_I) begin
		pin_meta_q <= PIN_I;
		pin_sync_q <= pin_meta_q;
	end

	// Data register has a plain reset value, no memory load
	always_ff @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			out_levels_q <= gmc_pkg::RST_OUT_LEVELS; // [RQ15]
			cfg_low_q <= gmc_pkg::RST_CFG_LOW;
			cfg_mid_q <= gmc_pkg::RST_CFG_MID;
			cfg_high_q <= gmc_pkg::RST_CFG_HIGH;
			pulldown_q <= gmc_pkg::RST_PULLDOWN;
		end else begin
			if (wr_out) begin
				out_levels_q <= {2'h0, REQ_I.wdata[5:0]}; // [RQ12]
			end
			if (wr_low) begin
				cfg_low_q <= REQ_I.wdata;
			end
			if (wr_mid) begin
				cfg_mid_q <= REQ_I.wdata;
			end
			if (wr_high) begin
				cfg_high_q <= {6'h00, REQ_I.wdata[gmc_pkg::CFG_HIGH_USED-1:0]}; // [RQ3]
			end
			if (wr_pd) begin
				pulldown_q <= REQ_I.wdata;
			end
		end
	end

	// Input register has no write path at all
	always_ff @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			rdata_q <= 8'h00;
		end else if (REQ_I.rd) begin
			rdata_q <= rd_mux; // [RQ13]
		end
	end

	// Registered pin side; costs one cycle of latency on every output
	always_ff @(posedge CLK_SYS_I) begin
		if (!RESET_N_I) begin
			pin_o_q <= '0;
			pin_oe_q <= '0;
			reserved_q <= '0;
			gate_q <= 4'h0;
			pulldown_en_q <= 4'h0;
			sense_sel_q <= 4'h0;
			margin_dis_q <= 1'b1;
			margin_up_q <= 1'b1;
			margin_dn_q <= 1'b1;
			mreset_q <= 1'b1;
			wdi_q <= 1'b0;
		end else begin
			pin_o_q <= drv_val;
			pin_oe_q <= drv_oe;
			reserved_q <= rsvd;
			gate_q <= gate_d;
			pulldown_en_q <= pd_d;
			sense_sel_q <= sense_sel;
			margin_dis_q <= margin_dis_d;
			margin_up_q <= margin_up_d;
			margin_dn_q <= margin_dn_d;
			mreset_q <= mreset_d;
			wdi_q <= wdi_d;
		end
	end

	assign RDATA_O = rdata_q;
	assign PIN_O = pin_o_q;
	assign PIN_OE_O = pin_oe_q;
	assign RESERVED_MODE_O = reserved_q;
	assign GATE_DRIVE_EN_O = gate_q;
	assign SENSE_PULLDOWN_EN_O = pulldown_en_q;
	assign TRACKING_SENSE_RETURN_SEL_O = sense_sel_q;
	assign MARGIN_DISABLE_N_O = margin_dis_q;
	assign MARGIN_RAISE_INPUT_N_O = margin_up_q;
	assign MARGIN_LOWER_INPUT_N_O = margin_dn_q;
	assign MANUAL_RESET_INPUT_N_O = mreset_q;
	assign WATCHDOG_KICK_INPUT_O = wdi_q;

	// Assertions
	sequence s_out_write;
		REQ_I.wr && REQ_I.ext_page && REQ_I.addr == gmc_pkg::OFF_OUT_LEVELS;
	endsequence
	sequence s_pp_mode_steady;
		(mode[0] == gmc_pkg::MODE_PUSH_PULL_IO) [*2];
	endsequence
	// Split fields need the low config byte to land whole and the two used high bits to land
	sequence s_cfg_low_write;
		REQ_I.wr && !REQ_I.ext_page && REQ_I.addr == gmc_pkg::OFF_CFG_LOW;
	endsequence
	sequence s_cfg_high_write;
		REQ_I.wr && !REQ_I.ext_page && REQ_I.addr == gmc_pkg::OFF_CFG_HIGH;
	endsequence

	pp_drives_bit_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		s_pp_mode_steady |=> PIN_OE_O[0] && PIN_O[0] == $past(out_levels_q[0]))
		else $error("push-pull pin 1 not following data bit"); // [RQ11]
	in_write_ignored_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		REQ_I.wr && REQ_I.ext_page && REQ_I.addr == gmc_pkg::OFF_IN_LEVELS
		|=> $stable(out_levels_q) && $stable(cfg_low_q))
		else $error("input register write changed state"); // [RQ13]
	out_write_store_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		s_out_write |=> out_levels_q == {2'h0, $past(REQ_I.wdata[5:0])})
		else $error("output register write lost"); // [RQ12]
	od_never_high_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		$past(mode[2] == gmc_pkg::MODE_OPEN_DRAIN_IO) && PIN_OE_O[2] |-> !PIN_O[2])
		else $error("open-drain pin driven high"); // [RQ19]
	input_report_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		REQ_I.rd && REQ_I.ext_page && REQ_I.addr == gmc_pkg::OFF_IN_LEVELS
		|=> RDATA_O == {2'h0, $past(pin_sync_q)})
		else $error("input register read mismatch"); // [RQ14]
	pin3_mode_join_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		mode[2] == {cfg_mid_q[0], cfg_low_q[7:6]} && mode[5] == {cfg_high_q[1:0], cfg_mid_q[7]})
		else $error("split mode field assembled wrongly"); // [RQ2]
	pulldown_follow_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		##1 SENSE_PULLDOWN_EN_O == $past(pulldown_q[7:4]))
		else $error("pulldown enable not following control bits"); // [RQ10]
	fault_pin_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		mode[4] == gmc_pkg::MODE_FAULT_PP |=> PIN_OE_O[4] && PIN_O[4] == $past(FUNC_I.first_fault_n))
		else $error("pin 5 not carrying first fault"); // [RQ17]
	gate_off_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		!sense_sel[1] |=> !GATE_DRIVE_EN_O[1])
		else $error("gate drive on without tracking mode"); // [RQ8]
	reserved_flag_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		mode[0] == gmc_pkg::MODE_CODE7 |=> RESERVED_MODE_O[0] && !PIN_OE_O[0])
		else $error("reserved code on pin 1 not flagged"); // [RQ4]
	cfg_low_store_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		s_cfg_low_write |=> cfg_low_q == $past(REQ_I.wdata))
		else $error("low config byte write lost"); // [RQ1]
	cfg_high_store_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		s_cfg_high_write |=> cfg_high_q[1:0] == $past(REQ_I.wdata[1:0]))
		else $error("high config byte write lost"); // [RQ3]
	cfg_high_rsvd_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		cfg_high_q[7:2] == 6'h00)
		else $error("reserved config bits stored"); // [RQ3]
	out_unused_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		out_levels_q[7:6] == 2'h0)
		else $error("unused output bits stored"); // [RQ12]
	// Open-drain must let go of the pin, never fight the pull-up
	od_io_release_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		mode[3] == gmc_pkg::MODE_OPEN_DRAIN_IO && out_levels_q[3]
		|=> !PIN_OE_O[3])
		else $error("open-drain pin 4 not released"); // [RQ19]
	pp_io_both_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		mode[4] == gmc_pkg::MODE_PUSH_PULL_IO
		|=> PIN_OE_O[4] && PIN_O[4] == $past(out_levels_q[4]))
		else $error("push-pull pin 5 not driven"); // [RQ6]
	logic_in_quiet_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		mode[2] == gmc_pkg::MODE_LOGIC_IN |=> !PIN_OE_O[2])
		else $error("logic input pin 3 driven"); // [RQ6]
	sense_quiet_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		mode[0] == gmc_pkg::MODE_SENSE
		|=> !PIN_OE_O[0] && TRACKING_SENSE_RETURN_SEL_O[0])
		else $error("sense pin 1 driven or not selected"); // [RQ7]
	margin_dis_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		mode[5] == gmc_pkg::MODE_SENSE |=> MARGIN_DISABLE_N_O == $past(pin_sync_q[5]))
		else $error("margin disable not following pin 6"); // [RQ7]
	gate_pg_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		sense_sel[0] && TRACK_POWER_GOOD_I[0] |=> GATE_DRIVE_EN_O[0])
		else $error("gate drive dropped after power good"); // [RQ9]
	pin5_rsvd_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		mode[4] == gmc_pkg::MODE_SENSE |=> RESERVED_MODE_O[4] && !PIN_OE_O[4])
		else $error("reserved code on pin 5 not flagged"); // [RQ4]
	// Fault levels pass through with one register of delay
	any_fault_od_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		mode[1] == gmc_pkg::MODE_FAULT_OD
		|=> PIN_OE_O[1] == !$past(FUNC_I.any_fault_n))
		else $error("open-drain any-fault on pin 2 wrong"); // [RQ16]
	data_ignored_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		mode[0] == gmc_pkg::MODE_FAULT_PP |=> PIN_O[0] == $past(FUNC_I.any_fault_n))
		else $error("data bit leaked into fault pin 1"); // [RQ20]
	second_fault_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		mode[5] == gmc_pkg::MODE_FAULT_PP
		|=> PIN_OE_O[5] && PIN_O[5] == $past(FUNC_I.second_fault_n))
		else $error("pin 6 not carrying second fault"); // [RQ17]
	wdo_drive_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		mode[5] == gmc_pkg::MODE_CODE6
		|=> PIN_OE_O[5] == !$past(FUNC_I.watchdog_expiry_n))
		else $error("watchdog expiry on pin 6 wrong"); // [RQ18]
	margin_up_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		mode[1] == gmc_pkg::MODE_CODE7 |=> MARGIN_RAISE_INPUT_N_O == $past(pin_sync_q[1]))
		else $error("margin raise not following pin 2"); // [RQ18]
	mreset_in_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		mode[3] == gmc_pkg::MODE_CODE7 |=> MANUAL_RESET_INPUT_N_O == $past(pin_sync_q[3]))
		else $error("manual reset not following pin 4"); // [RQ18]
	wdi_off_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		mode[4] != gmc_pkg::MODE_CODE7 |=> !WATCHDOG_KICK_INPUT_O)
		else $error("watchdog kick seen outside its mode"); // [RQ18]
	// Read data must stand until the next read
	read_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESET_N_I)
		!REQ_I.rd |=> $stable(RDATA_O))
		else $error("read data changed without a read"); // [RQ13]
endmodule

// ---- src/gmc_pkg.sv ----
// Package for the six-pin mode, output and input data logic.
// Assumes a byte-wide register port with an extended page select supplied by the caller.
package gmc_pkg;
	localparam int NUM_PINS = 6;
	localparam int MODE_W = 3;
	// Register offsets (8-bit address space)
	localparam logic [7:0] OFF_OUT_LEVELS = 8'h1A;
	localparam logic [7:0] OFF_IN_LEVELS = 8'h1B;
	localparam logic [7:0] OFF_CFG_LOW = 8'h1C;
	localparam logic [7:0] OFF_CFG_MID = 8'h1D;
	localparam logic [7:0] OFF_CFG_HIGH = 8'h1E;
	localparam logic [7:0] OFF_PULLDOWN = 8'h4E;
	// Field positions
	localparam int PIN1_LSB = 0;
	localparam int PIN2_LSB = 3;
	localparam int PIN3_LO_LSB = 6;
	localparam int PIN3_HI_BIT = 0;
	localparam int PIN4_LSB = 1;
	localparam int PIN5_LSB = 4;
	localparam int PIN6_LO_BIT = 7;
	localparam int PIN6_HI_LSB = 0;
	localparam int PULLDOWN_LSB = 4;
	localparam int CFG_HIGH_USED = 2;
	// Reset values
	localparam logic [7:0] RST_OUT_LEVELS = 8'h00;
	localparam logic [7:0] RST_CFG_LOW = 8'h00;
	localparam logic [7:0] RST_CFG_MID = 8'h00;
	localparam logic [7:0] RST_CFG_HIGH = 8'h00;
	localparam logic [7:0] RST_PULLDOWN = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	typedef enum logic [2:0] {
		MODE_SENSE = 3'h0,
		MODE_PUSH_PULL_IO = 3'h1,
		MODE_OPEN_DRAIN_IO = 3'h2,
		MODE_FAULT_PP = 3'h3,
		MODE_FAULT_OD = 3'h4,
		MODE_LOGIC_IN = 3'h5,
		MODE_CODE6 = 3'h6,
		MODE_CODE7 = 3'h7
	} gmc_mode_t;

	// Register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic ext_page;
		logic [7:0] addr;
		logic [7:0] wdata;
	} gmc_req_t;

	// Functions offered by the surrounding device to a pin
	typedef struct packed {
		logic any_fault_n;
		logic first_fault_n;
		logic second_fault_n;
		logic watchdog_expiry_n;
		logic fault_on_powerup_n;
	} gmc_func_t;
endpackage

// ---- verif/gmc_board.sv ----
// Board model for the six multi-function pins.
// Assumes one drive value and one enable per pin from the device; board pulls up.
`timescale 1ns/1ps
module gmc_board (
	input wire logic [5:0] drive_i,
	input wire logic [5:0] oe_i,
	input wire logic [5:0] ext_val_i,
	input wire logic [5:0] ext_en_i,
	output logic [5:0] pin_o
);
	// Device wins over board logic; released pins float to the pull-up unless the board drives them
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			pin_o[i] = oe_i[i] ? drive_i[i] : (ext_en_i[i] ? ext_val_i[i] : 1'b1);
		end
	end
endmodule

// ---- verif/tb_gmc_gpio_top.sv ----
// Self-checking bench for the pin mode, output and input data logic.
// Assumes the synchronous byte request port and 2-flop pin synchroniser of the design.
`timescale 1ns/1ps
module tb_gmc_gpio_top;
	logic clk;
	logic rst_n;
	gmc_pkg::gmc_req_t req;
	gmc_pkg::gmc_func_t func;
	logic [7:0] rdata;
	logic [5:0] pin_in, pin_out, pin_oe, ext_val, ext_en, rsv;
	logic [3:0] ramp, gate, pd, sense_sel;
	logic [3:0] pg;
	logic m_dis, m_up, m_dn, mr, watchdog_kick_input;
	int n_fail = 0;
	int n_compared = 0;

	gmc_gpio_top u_gmc_gpio_top (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .REQ_I(req),
		.RDATA_O(rdata), .PIN_I(pin_in), .PIN_O(pin_out), .PIN_OE_O(pin_oe), .FUNC_I(func),
		.TRACK_RAMP_ABOVE_I(ramp), .TRACK_POWER_GOOD_I(pg), .GATE_DRIVE_EN_O(gate),
		.SENSE_PULLDOWN_EN_O(pd), .TRACKING_SENSE_RETURN_SEL_O(sense_sel),
		.MARGIN_DISABLE_N_O(m_dis), .MARGIN_RAISE_INPUT_N_O(m_up),
		.MARGIN_LOWER_INPUT_N_O(m_dn), .MANUAL_RESET_INPUT_N_O(mr),
		.WATCHDOG_KICK_INPUT_O(watchdog_kick_input), .RESERVED_MODE_O(rsv));
	gmc_board u_gmc_board (.drive_i(pin_out), .oe_i(pin_oe), .ext_val_i(ext_val),
		.ext_en_i(ext_en), .pin_o(pin_in));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic finish_test();
		$display("Counts: compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Request held one cycle, launched and dropped at falling edges
	task automatic wr(input logic ext, input logic [7:0] a, input logic [7:0] d);
		req = '{1'b1, 1'b0, ext, a, d};
		@(negedge clk);
		req = '0;
	endtask

	task automatic rd(input logic ext, input logic [7:0] a, input logic [7:0] e, input string nm);
		req = '{1'b0, 1'b1, ext, a, 8'h00};
		@(negedge clk);
		req = '0;
		chk(nm, e, rdata);
	endtask

	initial begin
		#20000;
		n_fail++;
		$display("Error watchdog expired before tests ended");
		finish_test();
	end

	initial begin
		req = '0;
		func = '1;
		ext_val = 6'h00;
		ext_en = 6'h20;
		ramp = 4'h0;
		pg = 4'h0;
		rst_n = 1'b0;
		wt(2);
		rst_n = 1'b1;
		ramp = 4'h5;
		wt(4);
		chk("sense_sel", 8'h0F, {4'h0, sense_sel});
		chk("reserved", 8'h10, {2'h0, rsv});
		chk("gate", 8'h05, {4'h0, gate});
		chk("margin_dis", 8'h00, {7'h00, m_dis});
		ext_en = 6'h00;
		rd(1'b1, 8'h1A, 8'h00, "out_levels");
		for (int a = 8'h1C; a <= 8'h1E; a++) rd(1'b0, a[7:0], 8'h00, "cfg_reset");
		rd(1'b0, 8'h55, 8'h00, "unmapped");
		// All pins push-pull logic; configured legally only
		wr(1'b0, 8'h1C, 8'h49);
		wr(1'b0, 8'h1D, 8'h92);
		wr(1'b0, 8'h1E, 8'h00);
		wr(1'b1, 8'h1A, 8'h15);
		wt(3);
		chk("pp_oe", 8'h3F, {2'h0, pin_oe});
		chk("pp_out", 8'h15, {2'h0, pin_out});
		// Open-drain: drives only the low pins
		wr(1'b0, 8'h1C, 8'h92);
		wr(1'b0, 8'h1D, 8'h24);
		wr(1'b0, 8'h1E, 8'h01);
		wt(3);
		chk("od_oe", 8'h2A, {2'h0, pin_oe});
		chk("od_low", 8'h00, {2'h0, pin_out & pin_oe});
		wt(2);
		rd(1'b1, 8'h1B, 8'h15, "in_levels");
		// Logic inputs: board drives, register ignores writes
		wr(1'b0, 8'h1C, 8'h6D);
		wr(1'b0, 8'h1D, 8'hDB);
		wr(1'b0, 8'h1E, 8'h02);
		ext_en = 6'h3F;
		ext_val = 6'h2C;
		wt(4);
		chk("in_oe", 8'h00, {2'h0, pin_oe});
		rd(1'b1, 8'h1B, 8'h2C, "in_levels");
		wr(1'b1, 8'h1B, 8'hFF);
		rd(1'b1, 8'h1B, 8'h2C, "in_ro");
		wr(1'b1, 8'h1A, 8'hFF);
		wt(3);
		chk("in_oe_kept", 8'h00, {2'h0, pin_oe});
		rd(1'b1, 8'h1A, 8'h3F, "out_unused");
		rd(1'b0, 8'h1C, 8'h6D, "cfg_low");
		rd(1'b0, 8'h1D, 8'hDB, "cfg_mid");
		wr(1'b0, 8'h1E, 8'hFF);
		rd(1'b0, 8'h1E, 8'h03, "cfg_high");
		wr(1'b0, 8'h4E, 8'hF0);
		wt(2);
		chk("pulldown", 8'h0F, {4'h0, pd});
		rd(1'b0, 8'h4E, 8'hF0, "pulldown_reg");
		// Manual reset on pin4, watchdog kick on pin5
		wr(1'b0, 8'h1D, 8'h7E);
		ext_val = 6'h10;
		wt(4);
		chk("manual_reset", 8'h00, {7'h00, mr});
		chk("wd_kick", 8'h01, {7'h00, watchdog_kick_input});
		// Pin1 any-fault push-pull, active low
		wr(1'b0, 8'h1C, 8'h03);
		func.any_fault_n = 1'b0;
		wt(3);
		chk("any_fault", 8'h02, {6'h00, pin_oe[0], pin_out[0]});
		// Pins 2 and 3 are sense returns; power good holds the gate
		ramp = 4'h0;
		pg = 4'h2;
		wt(3);
		chk("sense_sel_23", 8'h06, {4'h0, sense_sel});
		chk("gate_pg", 8'h02, {4'h0, gate});
		// Margin inputs on pins 2 and 3, watchdog expiry on pin 6
		wr(1'b0, 8'h1C, 8'hFB);
		wr(1'b0, 8'h1D, 8'h7F);
		func.watchdog_expiry_n = 1'b0;
		wt(4);
		chk("margin_up", 8'h00, {7'h00, m_up});
		chk("margin_dn", 8'h00, {7'h00, m_dn});
		chk("wd_expiry", 8'h02, {6'h00, pin_oe[5], pin_out[5]});
		// Pin 6 second dedicated fault, push-pull
		wr(1'b0, 8'h1D, 8'hFF);
		wr(1'b0, 8'h1E, 8'h01);
		func.second_fault_n = 1'b0;
		wt(3);
		chk("second_fault", 8'h02, {6'h00, pin_oe[5], pin_out[5]});
		finish_test();
	end
endmodule
